// ===== pkg/acv_pkg.sv
// What this block does
// - mux routes one of eight channels
// - sample: buffer amp stage, then direct stage
// - idle machines gate clocks; power bit kills all
// - binary search, 8 or 10 bit resolution
// - trigger channel resets to 7, selectable
// - trigger disabled: ignored; scan bit selects continuous
// - edge mode: one sequence per edge, polarity
// - level mode: convert while trigger active
// - extra edge during conversion sets overrun
// - trigger start latency up to three cycles
// - trigger channel results are meaningless
// - trigger enabled: control 5 writes start nothing
// - level mode toggle never sets overrun
// - level still active at end: restart immediately
// - pad feeds mux; buffer enabled per channel
// - stop mode halts conversion, resumes after
// - wait halts conversion when wait select set
// - power bit cleared aborts conversion
// - power bit resets to zero
// - sequence done interrupt with local enable
// - per-position done flags, control 5 clear wins
// - port reads pin if enabled or trigger channel with trigger enabled, else 1
package acv_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_CTL1   = 4'h1;
  localparam logic [3:0] OFF_CTL2   = 4'h2;
  localparam logic [3:0] OFF_CTL3   = 4'h3;
  localparam logic [3:0] OFF_CTL5   = 4'h5;
  localparam logic [3:0] OFF_STAT0  = 4'h6;
  localparam logic [3:0] OFF_STAT1  = 4'h7;
  localparam logic [3:0] OFF_DIEN   = 4'h8;
  localparam logic [3:0] OFF_PORT   = 4'h9;
  localparam logic [3:0] OFF_RESH   = 4'hA;
  localparam logic [3:0] OFF_RESL   = 4'hB;
  localparam logic [3:0] OFF_RESIDX = 4'hC;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL2_PU    = 7;
  localparam int CTL2_WAIT  = 6;
  localparam int CTL2_LEVEL = 4;
  localparam int CTL2_POL   = 3;
  localparam int CTL2_TEN   = 2;
  localparam int CTL2_IEN   = 1;
  localparam int CTL1_TCH   = 0;
  localparam int CTL3_LEN   = 0;
  localparam int CTL5_RES8  = 7;
  localparam int CTL5_SCAN  = 5;
  localparam int CTL5_CH    = 0;
  localparam int STAT0_DONE = 7;
  localparam int STAT0_OVR  = 5;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTL1 = 8'h07;
  localparam logic [7:0] RST_CTL2 = 8'h00;
  localparam logic [7:0] RST_CTL3 = 8'h07;
  localparam logic [7:0] RST_CTL5 = 8'h00;
  localparam logic [7:0] RST_DIEN = 8'h00;
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [2:0] BUF_CYC  = 3'h2;
  localparam logic [2:0] FIN_CYC  = 3'h2;
  typedef enum {ACV_IDLE, ACV_BUF, ACV_FIN, ACV_CONV} acv_state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acv_bus_s;
  typedef struct packed {
    logic       mux_en;
    logic [2:0] mux_sel;
    logic       sh_clk_en;
    logic       amp_stage;
    logic       direct_stage;
    logic       sar_clk_en;
    logic [9:0] dac_code;
    logic       bias_en;
  } acv_analog_s;
endpackage : acv_pkg

// ===== verilog/acv_ctrl.sv
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module acv_ctrl (
  input  wire logic             i_mclk,    // bus clock, 10 MHz
  input  wire logic             i_rst,     // async reset, active high
  input  wire acv_pkg::acv_bus_s i_bus,     // register port request
  output logic [7:0]            o_rdata,   // read data, cycle after read
  input  wire logic [7:0]       i_pin,     // pad levels of the channels
  input  wire logic             i_cmp,     // comparator: sample >= dac
  input  wire logic             i_stop,    // stop mode active
  input  wire logic             i_wait,    // wait mode active
  output acv_pkg::acv_analog_s  o_ana,     // analog steering
  output logic [7:0]            o_pad_ien, // per pad digital buffer on
  output logic                  o_irq      // sequence done request
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         ctl1;
    logic [7:0]         ctl2;
    logic [7:0]         ctl3;
    logic [7:0]         ctl5;
    logic [7:0]         dien;
    logic [7:0]         port;
    logic [7:0]         pos_done;
    logic               done;
    logic               ovr;
    logic [7:0]         rdata;
    acv_pkg::acv_state_e st;
    logic [2:0]         cnt;
    logic [3:0]         bitn;
    logic [9:0]         sar;
    logic [2:0]         pos;
    logic [2:0]         idx;
    logic [7:0][9:0]    res;
    logic               trg_s1;
    logic               trg_s2;
    logic               trg_s3;
    acv_pkg::acv_analog_s ana;
    logic               irq;
  } acv_ctrl_s;

  acv_ctrl_s r;
  acv_ctrl_s next_r;

  function automatic logic [7:0] fld8(input logic [7:0] v, input int lo,
                                      input int w);
    fld8 = (v >> lo) & ((8'h01 << w) - 8'h01);
  endfunction : fld8

  function automatic logic [2:0] seqlen(input logic [7:0] c3);
    seqlen = 3'(fld8(c3, acv_pkg::CTL3_LEN, 3));
  endfunction : seqlen

  logic       wr_c5;
  logic       pu;
  logic       ten;
  logic       lvl;
  logic       pol;
  logic [2:0] tch;
  logic       halt;
  logic       trg_now;
  logic       trg_prev;
  logic       edge_hit;
  logic       lvl_act;
  logic       busy;
  logic       res8;
  logic [9:0] rv;

  always_comb begin
    next_r  = r;
    pu      = r.ctl2[acv_pkg::CTL2_PU];
    ten     = r.ctl2[acv_pkg::CTL2_TEN];
    lvl     = r.ctl2[acv_pkg::CTL2_LEVEL];
    pol     = r.ctl2[acv_pkg::CTL2_POL];
    tch     = 3'(fld8(r.ctl1, acv_pkg::CTL1_TCH, 3));
    res8    = r.ctl5[acv_pkg::CTL5_RES8];
    halt    = i_stop || (i_wait && r.ctl2[acv_pkg::CTL2_WAIT]);
    wr_c5   = i_bus.wr && i_bus.addr == acv_pkg::OFF_CTL5;
    busy    = r.st != acv_pkg::ACV_IDLE;
    rv      = 10'h000;
    // ---------------------------------------------------------------
    // trigger sync: s1 feeds s2 only
    // ---------------------------------------------------------------
    next_r.trg_s1 = i_pin[tch];
    next_r.trg_s2 = r.trg_s1;
    next_r.trg_s3 = r.trg_s2;
    trg_now  = r.trg_s2 ~^ pol;
    trg_prev = r.trg_s3 ~^ pol;
    edge_hit = ten && !lvl && trg_now && !trg_prev;
    lvl_act  = ten && lvl && trg_now;
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    if (i_bus.wr) begin
      case (i_bus.addr)
        acv_pkg::OFF_CTL1: next_r.ctl1 = i_bus.wdata;
        acv_pkg::OFF_CTL2: next_r.ctl2 = i_bus.wdata;
        acv_pkg::OFF_CTL3: next_r.ctl3 = i_bus.wdata;
        acv_pkg::OFF_CTL5: next_r.ctl5 = i_bus.wdata;
        acv_pkg::OFF_DIEN: next_r.dien = i_bus.wdata;
        acv_pkg::OFF_STAT0: begin
          if (i_bus.wdata[acv_pkg::STAT0_DONE]) next_r.done = 1'b0;
          if (i_bus.wdata[acv_pkg::STAT0_OVR]) next_r.ovr = 1'b0;
        end
        acv_pkg::OFF_RESIDX: next_r.idx = i_bus.wdata[2:0];
        default: ;
      endcase
    end
    for (int k = 0; k < 8; k++) begin
      next_r.port[k] = (r.dien[k] || (ten && tch == 3'(k))) ?
                       i_pin[k] : 1'b1;
    end
    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    if (busy && edge_hit) next_r.ovr = 1'b1;
    case (r.st)
      acv_pkg::ACV_IDLE: begin
        if (pu && !halt && (edge_hit || lvl_act)) begin
          next_r.st  = acv_pkg::ACV_BUF;
          next_r.pos = 3'h0;
          next_r.cnt = 3'h0;
        end
      end
      acv_pkg::ACV_BUF: begin
        if (!halt) next_r.cnt = r.cnt + 3'h1;
        if (!halt && r.cnt == acv_pkg::BUF_CYC - 3'h1) begin
          next_r.st  = acv_pkg::ACV_FIN;
          next_r.cnt = 3'h0;
        end
      end
      acv_pkg::ACV_FIN: begin
        if (!halt) next_r.cnt = r.cnt + 3'h1;
        if (!halt && r.cnt == acv_pkg::FIN_CYC - 3'h1) begin
          next_r.st   = acv_pkg::ACV_CONV;
          next_r.bitn = res8 ? 4'h7 : 4'h9;
          next_r.sar  = res8 ? 10'h080 : 10'h200;
        end
      end
      acv_pkg::ACV_CONV: begin
        if (!halt) begin
          if (!i_cmp) next_r.sar[r.bitn] = 1'b0;
          if (r.bitn != 4'h0) begin
            next_r.bitn = r.bitn - 4'h1;
            next_r.sar[r.bitn - 4'h1] = 1'b1;
          end else begin
            rv = r.sar;
            if (!i_cmp) rv[0] = 1'b0;
            next_r.res[r.pos] = res8 ? {rv[7:0], 2'b00} : rv;
            next_r.pos_done[r.pos] = 1'b1;
            next_r.cnt = 3'h0;
            next_r.pos = r.pos + 3'h1;
            next_r.st  = acv_pkg::ACV_BUF;
            if (r.pos == seqlen(r.ctl3)) begin
              next_r.done = 1'b1;
              next_r.pos  = 3'h0;
              if (ten) begin
                if (!lvl_act) next_r.st = acv_pkg::ACV_IDLE;
              end else if (!r.ctl5[acv_pkg::CTL5_SCAN]) begin
                next_r.st = acv_pkg::ACV_IDLE;
              end
            end
          end
        end
      end
      default: next_r.st = acv_pkg::ACV_IDLE;
    endcase
    if (wr_c5) begin
      next_r.pos_done = 8'h00;
      next_r.done = 1'b0;
      if (!ten && pu) begin
        next_r.st  = acv_pkg::ACV_BUF;
        next_r.pos = 3'h0;
        next_r.cnt = 3'h0;
      end
    end
    if (!pu || (i_bus.wr && i_bus.addr == acv_pkg::OFF_CTL2 &&
        !i_bus.wdata[acv_pkg::CTL2_PU])) begin
      next_r.st = acv_pkg::ACV_IDLE;
    end
    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    next_r.rdata = 8'h00;
    if (i_bus.rd) begin
      case (i_bus.addr)
        acv_pkg::OFF_CTL1:  next_r.rdata = r.ctl1;
        acv_pkg::OFF_CTL2:  next_r.rdata = r.ctl2;
        acv_pkg::OFF_CTL3:  next_r.rdata = r.ctl3;
        acv_pkg::OFF_CTL5:  next_r.rdata = r.ctl5;
        acv_pkg::OFF_STAT0: next_r.rdata = {r.done, 1'b0, r.ovr, 2'b00,
                                            r.pos};
        acv_pkg::OFF_STAT1: next_r.rdata = r.pos_done;
        acv_pkg::OFF_DIEN:  next_r.rdata = r.dien;
        acv_pkg::OFF_PORT:  next_r.rdata = r.port;
        // trigger channel result kept but meaningless while triggering
        acv_pkg::OFF_RESH:  next_r.rdata = r.res[r.idx][9:2];
        acv_pkg::OFF_RESL:  next_r.rdata = {r.res[r.idx][1:0], 6'h00};
        acv_pkg::OFF_RESIDX: next_r.rdata = {5'h00, r.idx};
        default:            next_r.rdata = 8'h00;
      endcase
    end
    // ---------------------------------------------------------------
    // analog steering and clock gating
    // ---------------------------------------------------------------
    next_r.ana.bias_en      = next_r.ctl2[acv_pkg::CTL2_PU];
    next_r.ana.mux_en       = next_r.st != acv_pkg::ACV_IDLE;
    next_r.ana.mux_sel      = 3'(fld8(next_r.ctl5, acv_pkg::CTL5_CH, 3))
                              + next_r.pos;
    next_r.ana.amp_stage    = next_r.st == acv_pkg::ACV_BUF;
    next_r.ana.direct_stage = next_r.st == acv_pkg::ACV_FIN;
    next_r.ana.sh_clk_en    = (next_r.ana.amp_stage ||
                               next_r.ana.direct_stage) && !halt;
    next_r.ana.sar_clk_en   = next_r.st == acv_pkg::ACV_CONV && !halt;
    // 8-bit search drives the top eight DAC bits, spanning the full-scale range
    next_r.ana.dac_code     = next_r.ctl5[acv_pkg::CTL5_RES8] ?
                              {next_r.sar[7:0], 2'b00} : next_r.sar;
    next_r.irq = (next_r.done && next_r.ctl2[acv_pkg::CTL2_IEN]);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r      <= '0;
      r.ctl1 <= acv_pkg::RST_CTL1;
      r.ctl2 <= acv_pkg::RST_CTL2;
      r.ctl3 <= acv_pkg::RST_CTL3;
      r.ctl5 <= acv_pkg::RST_CTL5;
      r.dien <= acv_pkg::RST_DIEN;
      r.port <= acv_pkg::RST_PORT;
      r.st   <= acv_pkg::ACV_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata   = r.rdata;
  assign o_ana     = r.ana;
  assign o_pad_ien = r.dien;
  assign o_irq     = r.irq;
endmodule : acv_ctrl

// ===== tb/acv_ctrl_assertions.sv
`timescale 1ns/100ps
module acv_ctrl_assertions (
  input wire logic                 i_mclk,   // bus clock
  input wire logic                 i_rst,    // async reset
  input wire acv_pkg::acv_bus_s    i_bus,    // register request
  input wire logic [7:0]           o_rdata,  // read data
  input wire logic                 i_stop,   // stop mode
  input wire acv_pkg::acv_analog_s o_ana,    // analog steering
  input wire logic [7:0]           o_pad_ien // pad buffers
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ---------------------------------------------------------------
  // sampling, power and register port
  // ---------------------------------------------------------------
  sequence s_power_off;
    i_bus.wr && i_bus.addr == acv_pkg::OFF_CTL2 && !i_bus.wdata[7];
  endsequence
  a_stage_order: assert property ($rose(o_ana.direct_stage) |->
    $past(o_ana.amp_stage)) else $error("direct stage without amp");
  a_one_stage: assert property (!(o_ana.amp_stage &&
    o_ana.direct_stage)) else $error("both sample stages on");
  a_clock_gate: assert property ((o_ana.sh_clk_en ||
    o_ana.sar_clk_en) |-> o_ana.bias_en) else $error("clock while off");
  a_power_abort: assert property (s_power_off |-> ##[1:2]
    (!o_ana.sh_clk_en && !o_ana.sar_clk_en)) else $error("no abort");
  a_power_reset: assert property ($fell(i_rst) |->
    !o_ana.bias_en) else $error("powered after reset");
  a_stop_freeze: assert property (i_stop && $past(i_stop) |->
    $stable(o_ana.dac_code)) else $error("converting in stop");
  a_mux_hold: assert property (o_ana.sar_clk_en &&
    $past(o_ana.sar_clk_en) |-> $stable(o_ana.mux_sel))
    else $error("channel moved in conversion");
  a_ien_follow: assert property (i_bus.wr &&
    i_bus.addr == acv_pkg::OFF_DIEN |=> ##1
    o_pad_ien == $past(i_bus.wdata, 2)) else $error("pad enable stale");
  a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data outside slot");
endmodule : acv_ctrl_assertions
bind acv_ctrl acv_ctrl_assertions acv_ctrl_assertions_i (.i_mclk, .i_rst,
  .i_bus, .o_rdata, .i_stop, .o_ana, .o_pad_ien);

// ===== tb/acv_far_side.sv
`timescale 1ns/100ps
module acv_far_side (
  input  wire logic                 i_mclk, // bus clock
  input  wire acv_pkg::acv_analog_s i_ana,  // steering from the block
  input  wire logic [7:0]           i_lvl,  // pad levels to present
  output logic [7:0]                o_pin,  // pads
  output logic                      o_cmp   // comparator
);
  logic [9:0] held;
  assign o_pin = i_lvl;
  // each channel shows its own number in the sample, so a wrong pick changes the result
  always_ff @(posedge i_mclk) begin
    if (i_ana.direct_stage) begin
      held <= {i_ana.mux_sel, 7'h2A};
    end
  end
  assign o_cmp = (held >= i_ana.dac_code);
endmodule : acv_far_side

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic                 i_mclk = 1'b0;
  logic                 rst    = 1'b1;
  acv_pkg::acv_bus_s    bus    = '0;
  logic [7:0]           lvl    = 8'h25;
  logic                 stp    = 1'b0;
  logic                 wt     = 1'b0;
  logic [7:0]           rdata, pin_w, ien, d;
  logic                 cmp, irq;
  acv_pkg::acv_analog_s ana;
  int                   errors = 0;
  int                   compares = 0;
  always #50 i_mclk = ~i_mclk;
  acv_ctrl acv_ctrl_i (.i_mclk(i_mclk), .i_rst(rst), .i_bus(bus),
    .o_rdata(rdata), .i_pin(pin_w), .i_cmp(cmp), .i_stop(stp),
    .i_wait(wt), .o_ana(ana), .o_pad_ien(ien), .o_irq(irq));
  acv_far_side acv_far_side_i (.i_mclk(i_mclk), .i_ana(ana), .i_lvl(lvl),
    .o_pin(pin_w), .o_cmp(cmp));
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge i_mclk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rraw(input logic [3:0] a);
    @(posedge i_mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_mclk) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rraw
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    rraw(a);
    chk(d, exp);
  endtask : rd
  // polls status; a bounded poll also proves that nothing finished
  task automatic wait_done(input int lim, input logic [7:0] exp);
    int n;
    n = 0;
    d = 8'h00;
    while (d[7] !== 1'b1 && n < lim) begin
      rraw(acv_pkg::OFF_STAT0);
      n++;
    end
    chk(d & 8'hA0, exp);
  endtask : wait_done
  task automatic res(input logic [2:0] pos, input logic [2:0] ch);
    wr(acv_pkg::OFF_RESIDX, {5'h00, pos});
    rd(acv_pkg::OFF_RESH, {ch, 5'h0A});
  endtask : res
  task automatic tally_and_finish;
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_mclk);
    rst <= 1'b0;
    rd(acv_pkg::OFF_CTL1, 8'h07);
    rd(acv_pkg::OFF_CTL2, 8'h00);
    rd(acv_pkg::OFF_PORT, 8'hFF);
    rd(4'hF, 8'h00);
    wr(acv_pkg::OFF_DIEN, 8'h0F);
    rd(acv_pkg::OFF_PORT, 8'hF5);
    wr(acv_pkg::OFF_CTL2, 8'h82);
    wr(acv_pkg::OFF_CTL3, 8'h01);
    wr(acv_pkg::OFF_CTL5, 8'h02);
    wait_done(100, 8'h80);
    chk({7'h00, irq}, 8'h01);
    rd(acv_pkg::OFF_STAT1, 8'h03);
    res(3'h0, 3'h2);
    rd(acv_pkg::OFF_RESL, 8'h80);
    res(3'h1, 3'h3);
    wr(acv_pkg::OFF_STAT0, 8'h80);
    #1 chk({7'h00, irq}, 8'h00);
    wr(acv_pkg::OFF_CTL5, 8'h86);
    rd(acv_pkg::OFF_STAT1, 8'h00);
    @(posedge i_mclk) stp <= 1'b1;
    repeat (10) @(posedge i_mclk);
    stp <= 1'b0;
    wait_done(100, 8'h80);
    res(3'h1, 3'h7);
    wr(acv_pkg::OFF_STAT0, 8'h80);
    wr(acv_pkg::OFF_CTL2, 8'hC2);
    wt <= 1'b1;
    wr(acv_pkg::OFF_CTL5, 8'h86);
    wait_done(20, 8'h00);
    wt <= 1'b0;
    wait_done(100, 8'h80);
    wr(acv_pkg::OFF_STAT0, 8'h80);
    wr(acv_pkg::OFF_CTL2, 8'h8C);
    wr(acv_pkg::OFF_CTL5, 8'h00);
    wait_done(20, 8'h00);
    @(posedge i_mclk) lvl <= 8'hA5;
    repeat (5) @(posedge i_mclk);
    #1 chk({7'h00, ana.sh_clk_en | ana.sar_clk_en}, 8'h01);
    @(posedge i_mclk) lvl <= 8'h25;
    repeat (3) @(posedge i_mclk);
    lvl <= 8'hA5;
    wait_done(100, 8'hA0);
    wr(acv_pkg::OFF_STAT0, 8'hA0);
    wr(acv_pkg::OFF_CTL2, 8'h9C);
    wait_done(100, 8'h80);
    wr(acv_pkg::OFF_STAT0, 8'h80);
    wait_done(100, 8'h80);
    wr(acv_pkg::OFF_CTL2, 8'h00);
    rd(acv_pkg::OFF_CTL2, 8'h00);
    tally_and_finish();
  end
  initial begin
    #500000;
    errors++;
    tally_and_finish();
  end
endmodule : tb_top
